// >>> src/fasp_consts.vh
// Purpose: Shared constants of the FIFO serial port
// Assumes: 32-bit AXI4-Lite register bus, byte-wide registers except the 13-bit count register
// Notes:   Offsets are byte addresses, one aligned word each
`ifndef FASP_CONSTS_VH
`define FASP_CONSTS_VH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define FASP_OFS_FORMAT  8'h00
`define FASP_OFS_BITRATE 8'h04
`define FASP_OFS_CONTROL 8'h08
`define FASP_OFS_TXDATA  8'h0C
`define FASP_OFS_FLAGS   8'h10
`define FASP_OFS_RXDATA  8'h14
`define FASP_OFS_FIFOCTL 8'h18
`define FASP_OFS_COUNT   8'h1C

// ----------------------------------------------------------------
// Field positions and writable masks
// ----------------------------------------------------------------
`define FASP_FMT_CHR   6
`define FASP_FMT_PE    5
`define FASP_FMT_ODD   4
`define FASP_FMT_STOP  3
`define FASP_FMT_MASK  8'h78
`define FASP_CTL_TIE   7
`define FASP_CTL_RIE   6
`define FASP_CTL_TE    5
`define FASP_CTL_RE    4
`define FASP_CTL_MASK  8'hF3
`define FASP_FCR_MCE   3
`define FASP_FCR_TX_FIFO_CLEAR 2
`define FASP_FCR_RFRST 1
`define FASP_FCR_LOOP  0
// Flag bits: 0 ready, 1 rx high, 2 parity, 3 framing, 4 break,
// 5 tx low, 6 tx done
`define FASP_FLAG_RESET 7'h60

// ----------------------------------------------------------------
// Timing and responses
// ----------------------------------------------------------------
`define FASP_RX_IDLE_TICKS 8'hFF
`define FASP_RESP_OKAY     2'h0
`define FASP_RESP_SLVERR   2'h2

`endif

// >>> src/fasp_fifo.v
// Purpose: 16-entry byte FIFO with occupancy count
// Assumes: Push and pop may come in the same cycle
// Notes:   Push when full and pop when empty are ignored
`timescale 1ns/1ps

module fasp_fifo (
  input  wire       clk,
  input  wire       rst_n,
  input  wire       clr,
  input  wire       push,
  input  wire [7:0] din,
  input  wire       pop,
  output wire [7:0] dout,
  output wire [4:0] count,
  output wire       full,
  output wire       empty
);

  reg [7:0] mem [0:15];
  reg [3:0] wp;
  reg [3:0] rp;
  reg [4:0] cnt;
  wire      do_push = push & ~full;
  wire      do_pop  = pop & ~empty;

  assign dout  = mem[rp];
  assign count = cnt;
  assign full  = (cnt == 5'h10);
  assign empty = (cnt == 5'h00);

  // Storage has no reset; only pointers and count define contents
  always @(posedge clk) begin
    if (do_push) begin
      mem[wp] <= din;
    end
  end

  // Pointer and count update; clear empties without touching data
  always @(posedge clk) begin
    if (!rst_n || clr) begin
      wp  <= 4'h0;
      rp  <= 4'h0;
      cnt <= 5'h00;
    end else begin
      if (do_push) begin
        wp <= wp + 4'h1;
      end
      if (do_pop) begin
        rp <= rp + 4'h1;
      end
      if (do_push && !do_pop) begin
        cnt <= cnt + 5'h01;
      end else if (do_pop && !do_push) begin
        cnt <= cnt - 5'h01;
      end
    end
  end

endmodule

// >>> src/fasp_serial_port.v
// Purpose: Asynchronous serial port with 16-byte FIFOs, AXI4-Lite
// Assumes: aclk at 10 MHz; pins are asynchronous to aclk
// Notes:   Overview of operation follows
// Overview of operation
// - Separate sixteen-character FIFOs for transmit and receive.
// - Character length bit: 0 gives eight data bits, 1 gives seven.
// - Parity enable adds one parity bit; stop bit selects one or two.
// - Frame is start, data, optional parity, stops; up to twelve bits.
// - Clock select 00 internal, 11 internal driving pin, 10 external.
// - Clock output starts as soon as control register selects it.
// - Clearing transmit enable reinitializes the transmit shift register.
// - Disabling directions keeps status flags and FIFO contents.
// - Clearing transmit enable releases the transmit line at once.
// - Enabling transmit gives mark state; enabling receive waits for start.
// - Detect framing, parity, rx high, data ready, break, tx low.
// - Both FIFO occupancy counts readable at any time.
// - Rx high flag when rx count exceeds trigger 1, 4, 8 or 14.
// - Tx low flag when tx count below trigger 8, 4, 2 or 1.
// - Modem control off: clear-to-send seen low, request-to-send held 0.
// - Data bits travel least significant bit first.
`timescale 1ns/1ps
`include "fasp_consts.vh"

module fasp_serial_port (
  input  wire        aclk,
  input  wire        aresetn,
  input  wire [7:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output wire        s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output wire        s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [7:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output wire        s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  output reg         txd_out,
  output wire        txd_oe,
  input  wire        rxd_in,
  input  wire        sck_in,
  output reg         sck_out,
  output wire        sck_oe,
  input  wire        cts_n_in,
  output reg         rts_n
);

  localparam ST_IDLE  = 3'h0;
  localparam ST_START = 3'h1;
  localparam ST_DATA  = 3'h2;
  localparam ST_PAR   = 3'h3;
  localparam ST_STOP  = 3'h4;

  // ----------------------------------------------------------------
  // Registers and shared wires
  // ----------------------------------------------------------------
  reg  [7:0] serial_format_reg;
  reg  [7:0] serial_control_reg;
  reg  [7:0] bit_rate_reg;
  reg  [7:0] fifo_control_reg;
  reg  [6:0] serial_flag_reg;
  reg  [6:0] flag_seen;
  reg        aw_have;
  reg  [7:0] aw_addr;
  reg        w_have;
  reg  [7:0] w_byte;
  reg        w_lane0;
  wire       tx_push;
  wire       rx_pop;
  wire [7:0] tx_dout;
  wire [4:0] tx_cnt;
  wire       tx_full;
  wire       tx_empty;
  wire [7:0] rx_dout;
  wire [4:0] rx_cnt;
  wire       rx_full;
  wire       rx_empty;
  reg        tx_pop;
  reg        rx_push;
  reg  [7:0] rx_sh;

  wire       char7    = serial_format_reg[`FASP_FMT_CHR];
  wire       par_on   = serial_format_reg[`FASP_FMT_PE];
  wire       par_odd  = serial_format_reg[`FASP_FMT_ODD];
  wire       two_stop = serial_format_reg[`FASP_FMT_STOP];
  wire       tx_on    = serial_control_reg[`FASP_CTL_TE];
  wire       rx_on    = serial_control_reg[`FASP_CTL_RE];
  wire [1:0] clk_sel  = serial_control_reg[1:0];
  wire       modem_on = fifo_control_reg[`FASP_FCR_MCE];
  wire [2:0] last_bit = char7 ? 3'h6 : 3'h7;

  // ----------------------------------------------------------------
  // FIFOs
  // ----------------------------------------------------------------
  // Clear bits hold the FIFO empty; stored bytes are left alone
  fasp_fifo u_tx_fifo (
    .clk   (aclk),
    .rst_n (aresetn),
    .clr   (fifo_control_reg[`FASP_FCR_TX_FIFO_CLEAR]),
    .push  (tx_push),
    .din   (w_byte),
    .pop   (tx_pop),
    .dout  (tx_dout),
    .count (tx_cnt),
    .full  (tx_full),
    .empty (tx_empty)
  );

  fasp_fifo u_rx_fifo (
    .clk   (aclk),
    .rst_n (aresetn),
    .clr   (fifo_control_reg[`FASP_FCR_RFRST]),
    .push  (rx_push),
    .din   (rx_sh),
    .pop   (rx_pop),
    .dout  (rx_dout),
    .count (rx_cnt),
    .full  (rx_full),
    .empty (rx_empty)
  );

  // ----------------------------------------------------------------
  // Pin synchronizers and bit clock
  // ----------------------------------------------------------------
  // Bits: 0 serial clock, 1 receive data, 2 clear-to-send
  reg  [2:0] pin_s1;
  reg  [2:0] pin_s2;
  reg  [2:0] pin_s3;
  reg  [2:0] pin_q;
  reg        sck_prev;
  reg  [7:0] half_div;
  wire       ext_clk  = (clk_sel == 2'h2);
  wire       half_hit = ~ext_clk && (half_div == 8'h00);
  wire       tick     = ext_clk ? (pin_q[0] & ~sck_prev) : (half_hit & ~sck_out);
  wire       cts_eff  = modem_on & pin_q[2];

  // Level changes only once stages two and three agree (glitch filter)
  always @(posedge aclk) begin
    if (!aresetn) begin
      pin_s1 <= 3'h7;
      pin_s2 <= 3'h7;
      pin_s3 <= 3'h7;
      pin_q  <= 3'h7;
    end else begin
      pin_s1 <= {cts_n_in, rxd_in, sck_in};
      pin_s2 <= pin_s1;
      pin_s3 <= pin_s2;
      pin_q  <= (~(pin_s2 ^ pin_s3) & pin_s3) | ((pin_s2 ^ pin_s3) & pin_q);
    end
  end

  // Divider toggles the 16x clock; its rising half gives the tick
  always @(posedge aclk) begin
    if (!aresetn) begin
      half_div <= 8'h00;
      sck_out  <= 1'b0;
      sck_prev <= 1'b1;
    end else begin
      sck_prev <= pin_q[0];
      if (half_hit) begin
        half_div <= bit_rate_reg;
        sck_out  <= ~sck_out;
      end else if (!ext_clk) begin
        half_div <= half_div - 8'h01;
      end
    end
  end

  assign sck_oe = (clk_sel == 2'h3);

  // ----------------------------------------------------------------
  // Transmitter
  // ----------------------------------------------------------------
  reg  [2:0] tx_state;
  reg  [3:0] tx_ph;
  reg  [2:0] tx_bit;
  reg  [7:0] tx_shift_reg;
  reg        tx_par;
  wire       tx_go   = ~tx_empty & ~cts_eff;
  wire       tx_end  = tick & (tx_ph == 4'hF);

  assign txd_oe = tx_on;

  // Frame sequencer; a disabled transmitter is held cleared
  always @(posedge aclk) begin
    tx_pop <= 1'b0;
    if (!aresetn || !tx_on) begin
      tx_state     <= ST_IDLE;
      tx_ph        <= 4'h0;
      tx_bit       <= 3'h0;
      tx_shift_reg <= 8'h00;
      tx_par       <= 1'b0;
    end else begin
      if (tick && tx_state != ST_IDLE) begin
        tx_ph <= tx_ph + 4'h1;
      end
      case (tx_state)
        ST_IDLE: begin
          if (tick && tx_go && !tx_pop) begin
            tx_shift_reg <= tx_dout;
            tx_pop       <= 1'b1;
            tx_par       <= 1'b0;
            tx_ph        <= 4'h0;
            tx_state     <= ST_START;
          end
        end
        ST_START: begin
          if (tx_end) begin
            tx_bit   <= 3'h0;
            tx_state <= ST_DATA;
          end
        end
        ST_DATA: begin
          if (tx_end) begin
            tx_shift_reg <= {1'b0, tx_shift_reg[7:1]};
            tx_par       <= tx_par ^ tx_shift_reg[0];
            tx_bit       <= tx_bit + 3'h1;
            if (tx_bit == last_bit) begin
              tx_bit   <= 3'h0;
              tx_state <= par_on ? ST_PAR : ST_STOP;
            end
          end
        end
        ST_PAR: begin
          if (tx_end) begin
            tx_state <= ST_STOP;
          end
        end
        ST_STOP: begin
          if (tx_end) begin
            if (two_stop && tx_bit == 3'h0) begin
              tx_bit <= 3'h1;
            end else if (tx_go) begin
              // Next character follows without an idle bit
              tx_shift_reg <= tx_dout;
              tx_pop       <= 1'b1;
              tx_par       <= 1'b0;
              tx_state     <= ST_START;
            end else begin
              tx_state <= ST_IDLE;
            end
          end
        end
        default: begin
          tx_state <= ST_IDLE;
        end
      endcase
    end
  end

  // Line level registered from the sequencer state; mark when idle
  always @(posedge aclk) begin
    if (!aresetn) begin
      txd_out <= 1'b1;
    end else begin
      case (tx_state)
        ST_START: txd_out <= 1'b0;
        ST_DATA:  txd_out <= tx_shift_reg[0];
        ST_PAR:   txd_out <= tx_par ^ par_odd;
        default:  txd_out <= 1'b1;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Receiver
  // ----------------------------------------------------------------
  reg  [2:0] rx_state;
  reg  [3:0] rx_ph;
  reg  [2:0] rx_bit;
  reg        rx_par;
  reg        rx_perr;
  reg  [7:0] rx_idle;
  reg        ev_fer;
  reg        ev_per;
  reg        ev_brk;
  wire       rx_line = fifo_control_reg[`FASP_FCR_LOOP] ? txd_out : pin_q[1];
  wire       rx_mid  = tick & (rx_ph == 4'hF);

  // Start qualified at phase 7, later bits sampled mid-bit
  always @(posedge aclk) begin
    rx_push <= 1'b0;
    ev_fer  <= 1'b0;
    ev_per  <= 1'b0;
    ev_brk  <= 1'b0;
    if (!aresetn || !rx_on) begin
      rx_state <= ST_IDLE;
      rx_ph    <= 4'h0;
      rx_bit   <= 3'h0;
      rx_par   <= 1'b0;
      rx_perr  <= 1'b0;
    end else begin
      case (rx_state)
        ST_IDLE: begin
          if (tick) begin
            rx_ph <= rx_line ? 4'h0 : rx_ph + 4'h1;
            if (!rx_line && rx_ph == 4'h7) begin
              rx_ph    <= 4'h0;
              rx_bit   <= 3'h0;
              rx_sh    <= 8'h00;
              rx_par   <= 1'b0;
              rx_perr  <= 1'b0;
              rx_state <= ST_DATA;
            end
          end
        end
        ST_DATA: begin
          if (tick) begin
            rx_ph <= rx_ph + 4'h1;
          end
          if (rx_mid) begin
            rx_sh[rx_bit] <= rx_line;
            rx_par        <= rx_par ^ rx_line;
            rx_bit        <= rx_bit + 3'h1;
            if (rx_bit == last_bit) begin
              rx_state <= par_on ? ST_PAR : ST_STOP;
            end
          end
        end
        ST_PAR: begin
          if (tick) begin
            rx_ph <= rx_ph + 4'h1;
          end
          if (rx_mid) begin
            rx_perr  <= rx_line ^ rx_par ^ par_odd;
            rx_par   <= rx_par | rx_line;
            rx_state <= ST_STOP;
          end
        end
        ST_STOP: begin
          if (tick) begin
            rx_ph <= rx_ph + 4'h1;
          end
          // Only the first stop bit is checked
          if (rx_mid) begin
            ev_fer <= ~rx_line;
            ev_per <= rx_perr;
            ev_brk <= ~rx_line & (rx_sh == 8'h00) & ~(par_on & rx_par);
            rx_push <= ~(~rx_line & (rx_sh == 8'h00) & ~(par_on & rx_par))
                       & ~serial_flag_reg[4];
            rx_state <= ST_IDLE;
          end
        end
        default: begin
          rx_state <= ST_IDLE;
        end
      endcase
    end
  end

  // Quiet-line counter in ticks for the data-ready flag
  always @(posedge aclk) begin
    if (!aresetn || !rx_on || rx_state != ST_IDLE || rx_push) begin
      rx_idle <= 8'h00;
    end else if (tick && rx_idle != `FASP_RX_IDLE_TICKS) begin
      rx_idle <= rx_idle + 8'h01;
    end
  end

  // Request-to-send asserts high only when receive space runs out
  always @(posedge aclk) begin
    if (!aresetn) begin
      rts_n <= 1'b0;
    end else begin
      rts_n <= modem_on & rx_full;
    end
  end

  // ----------------------------------------------------------------
  // Status flags
  // ----------------------------------------------------------------
  reg  [4:0] rx_trig;
  reg  [4:0] tx_trig;
  wire       rdf_set = (rx_cnt > rx_trig);
  wire       tx_fifo_low_flag_set = (tx_cnt < tx_trig);
  wire       tx_done_flag_set = (tx_state == ST_IDLE) & tx_empty;
  wire       dr_set  = ~rx_empty & ~rdf_set & (rx_idle == `FASP_RX_IDLE_TICKS);
  wire [6:0] flag_set = {tx_done_flag_set, tx_fifo_low_flag_set, ev_brk, ev_fer, ev_per, rdf_set, dr_set};
  wire       wr_go   = aw_have & w_have & ~s_axi_bvalid;
  wire       wr_flag = wr_go & w_lane0 & (aw_addr[7:2] == `FASP_OFS_FLAGS >> 2);
  wire [6:0] flag_clr = wr_flag ? (flag_seen & ~w_byte[6:0]) : 7'h00;
  wire       rd_go   = s_axi_arvalid & ~s_axi_rvalid;
  wire [5:0] rd_idx  = s_axi_araddr[7:2];

  // Trigger decode
  always @* begin
    case (fifo_control_reg[7:6])
      2'h0:    rx_trig = 5'h01;
      2'h1:    rx_trig = 5'h04;
      2'h2:    rx_trig = 5'h08;
      default: rx_trig = 5'h0E;
    endcase
    case (fifo_control_reg[5:4])
      2'h0:    tx_trig = 5'h08;
      2'h1:    tx_trig = 5'h04;
      2'h2:    tx_trig = 5'h02;
      default: tx_trig = 5'h01;
    endcase
  end

  // Set beats clear; enables never touch flags
  always @(posedge aclk) begin
    if (!aresetn) begin
      serial_flag_reg <= `FASP_FLAG_RESET;
      flag_seen       <= 7'h00;
    end else begin
      serial_flag_reg <= (serial_flag_reg & ~flag_clr) | flag_set;
      if (rd_go && rd_idx == (`FASP_OFS_FLAGS >> 2)) begin
        flag_seen <= serial_flag_reg;
      end else if (wr_flag) begin
        flag_seen <= 7'h00;
      end
    end
  end

  // ----------------------------------------------------------------
  // AXI4-Lite slave
  // ----------------------------------------------------------------
  assign s_axi_awready = ~aw_have;
  assign s_axi_wready  = ~w_have;
  assign s_axi_arready = ~s_axi_rvalid;
  assign tx_push = wr_go & w_lane0 & (aw_addr[7:2] == `FASP_OFS_TXDATA >> 2);
  assign rx_pop  = rd_go & (rd_idx == (`FASP_OFS_RXDATA >> 2));

  // Address and data latched in any order, write done once both held
  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_have            <= 1'b0;
      aw_addr            <= 8'h00;
      w_have             <= 1'b0;
      w_byte             <= 8'h00;
      w_lane0            <= 1'b0;
      s_axi_bvalid       <= 1'b0;
      s_axi_bresp        <= `FASP_RESP_OKAY;
      serial_format_reg  <= 8'h00;
      serial_control_reg <= 8'h00;
      bit_rate_reg       <= 8'hFF;
      fifo_control_reg   <= 8'h00;
    end else begin
      if (s_axi_awvalid && !aw_have) begin
        aw_have <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && !w_have) begin
        w_have  <= 1'b1;
        w_byte  <= s_axi_wdata[7:0];
        w_lane0 <= s_axi_wstrb[0];
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      if (wr_go) begin
        aw_have      <= 1'b0;
        w_have       <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (aw_addr[7:5] == 3'h0) ? `FASP_RESP_OKAY : `FASP_RESP_SLVERR;
        if (w_lane0) begin
          case (aw_addr[7:2])
            (`FASP_OFS_FORMAT >> 2):  serial_format_reg <= w_byte & `FASP_FMT_MASK;
            (`FASP_OFS_BITRATE >> 2): bit_rate_reg <= w_byte;
            (`FASP_OFS_CONTROL >> 2): serial_control_reg <= w_byte & `FASP_CTL_MASK;
            (`FASP_OFS_FIFOCTL >> 2): fifo_control_reg <= w_byte;
            default: begin
            end
          endcase
        end
      end
    end
  end

  // Read answer registered; a read of receive data pops one byte
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h00000000;
      s_axi_rresp  <= `FASP_RESP_OKAY;
    end else if (rd_go) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= (s_axi_araddr[7:5] == 3'h0) ? `FASP_RESP_OKAY : `FASP_RESP_SLVERR;
      case (rd_idx)
        (`FASP_OFS_FORMAT >> 2):  s_axi_rdata <= {24'h000000, serial_format_reg};
        (`FASP_OFS_BITRATE >> 2): s_axi_rdata <= {24'h000000, bit_rate_reg};
        (`FASP_OFS_CONTROL >> 2): s_axi_rdata <= {24'h000000, serial_control_reg};
        (`FASP_OFS_FLAGS >> 2):   s_axi_rdata <= {25'h0000000, serial_flag_reg};
        (`FASP_OFS_RXDATA >> 2):  s_axi_rdata <= {24'h000000, rx_dout};
        (`FASP_OFS_FIFOCTL >> 2): s_axi_rdata <= {24'h000000, fifo_control_reg};
        (`FASP_OFS_COUNT >> 2):   s_axi_rdata <= {19'h00000, tx_cnt, 3'h0, rx_cnt};
        default:                  s_axi_rdata <= 32'h00000000;
      endcase
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule

// >>> tb/fasp_line_model.sv
// Purpose: Remote serial partner on the line pins
// Assumes: Settings poked by the bench; even parity
// Notes:   A released txd reads as the inverse of its last level
`timescale 1ns/1ps
module fasp_line_model (
  input  wire aclk,
  input  wire txd_out,
  input  wire txd_oe,
  output reg  rxd_in,
  output reg  sck_in
);
  int         bit_cyc = 32, nb = 8, n_rx = 0, n_bad = 0;
  logic       par = 1'b0, two = 1'b0, held = 1'b1;
  logic [7:0] got;
  wire        line = txd_oe ? txd_out : ~held;
  // Last driven level, so a released line never looks valid
  always @(posedge aclk) if (txd_oe) held <= txd_out;
  // Free-running 16x clock, never paused
  initial begin
    rxd_in = 1'b1;
    sck_in = 1'b0;
    #37;
    forever #400 sck_in = ~sck_in;
  end
  // Frames from the port, sampled mid-bit
  always begin : rx_frame
    logic p;
    @(negedge line iff txd_oe);
    repeat (bit_cyc / 2) @(posedge aclk);
    got = 8'h00;
    p = 1'b0;
    for (int i = 0; i < nb; i++) begin
      repeat (bit_cyc) @(posedge aclk);
      got[i] = line;
      p ^= line;
    end
    if (par) begin
      repeat (bit_cyc) @(posedge aclk);
      n_bad += (line !== p);
    end
    for (int i = 0; i <= two; i++) begin
      repeat (bit_cyc) @(posedge aclk);
      n_bad += (line !== 1'b1);
    end
    n_rx++;
  end
  // A short bad stop avoids faking a new start bit
  task automatic send(input logic [7:0] d, input logic bad);
    logic p;
    begin
      p = 1'b0;
      @(posedge aclk);
      rxd_in <= 1'b0;
      repeat (bit_cyc) @(posedge aclk);
      for (int i = 0; i < nb; i++) begin
        rxd_in <= d[i];
        p ^= d[i];
        repeat (bit_cyc) @(posedge aclk);
      end
      if (par) begin
        rxd_in <= p;
        repeat (bit_cyc) @(posedge aclk);
      end
      rxd_in <= ~bad;
      repeat (bit_cyc * 3 / 4) @(posedge aclk);
      rxd_in <= 1'b1;
      repeat (bit_cyc * (two + 2)) @(posedge aclk);
    end
  endtask
endmodule

// >>> tb/fasp_serial_monitor.sv
// Purpose: Port-level checks of the FIFO serial port
// Assumes: Bus writes offer address and data together
// Notes:   Bound to every instance of the port
`timescale 1ns/1ps
module fasp_serial_monitor (
  input wire        aclk,
  input wire        aresetn,
  input wire [7:0]  s_axi_awaddr,
  input wire        s_axi_awvalid,
  input wire        s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0]  s_axi_wstrb,
  input wire        s_axi_wvalid,
  input wire        s_axi_wready,
  input wire [7:0]  s_axi_araddr,
  input wire        s_axi_arvalid,
  input wire        s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire        s_axi_rvalid,
  input wire        txd_out,
  input wire        txd_oe,
  input wire        sck_out,
  input wire        sck_oe,
  input wire        rts_n
);
  reg       modem_ctl_on;
  reg [7:0] ra;
  wire      wr = s_axi_awvalid & s_axi_awready & s_axi_wvalid & s_axi_wready & s_axi_wstrb[0];
  wire      ctl = wr && s_axi_awaddr == 8'h08;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Modem enable and read address, so checks need no design internals
  always @(posedge aclk) begin
    if (!aresetn) begin
      modem_ctl_on <= 1'b0;
      ra  <= 8'h00;
    end else begin
      if (wr && s_axi_awaddr == 8'h18) modem_ctl_on <= s_axi_wdata[3];
      if (s_axi_arvalid && s_axi_arready) ra <= s_axi_araddr;
    end
  end
  AST_CLK_OUT:
    assert property (ctl && s_axi_wdata[1:0] == 2'h3 |-> ##[1:3] sck_oe)
    else $error("clock output not started");
  AST_CLK_IN:
    assert property (ctl && s_axi_wdata[1:0] != 2'h3 |-> ##[1:3] !sck_oe)
    else $error("clock pin driven without output select");
  AST_CLK_RUN:
    assert property ($rose(sck_oe) |-> ##[1:300] (sck_out != $past(sck_out)))
    else $error("clock output not toggling");
  AST_TX_OFF:
    assert property (ctl && !s_axi_wdata[5] |-> ##[1:3] !txd_oe)
    else $error("transmit line not released");
  AST_MARK:
    assert property ($rose(txd_oe) |-> txd_out)
    else $error("transmit line not idle on enable");
  AST_START:
    assert property ($fell(txd_out) && txd_oe |-> (!txd_out || !txd_oe) [*8])
    else $error("start bit too short");
  AST_COUNTS:
    assert property (s_axi_rvalid && ra == 8'h1C |-> s_axi_rdata[31:13] == 0 &&
      s_axi_rdata[7:5] == 0 && s_axi_rdata[12:8] <= 16 && s_axi_rdata[4:0] <= 16)
    else $error("fifo count out of range");
  AST_RTS:
    assert property (!modem_ctl_on && !$past(modem_ctl_on, 3) |-> !rts_n)
    else $error("request line raised with modem control off");
endmodule
bind fasp_serial_port fasp_serial_monitor mon (.*);

// >>> tb/tb.sv
// Purpose: Self-checking bench for the FIFO serial port
// Assumes: aclk 100 ns; line model on txd, rxd and sck
// Notes:   Bit time 32 aclk internal, 128 aclk external
`timescale 1ns/1ps
module tb;
  logic        aclk = 1'b0, aresetn = 1'b0, cts_n_in = 1'b0;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, d, mk;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0]  s_axi_wstrb = 4'hF;
  logic [33:0] v;
  wire         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire         txd_out, txd_oe, rxd_in, sck_in, sck_out, sck_oe, rts_n;
  wire [1:0]   s_axi_bresp, s_axi_rresp;
  wire [31:0]  s_axi_rdata;
  int          n_fail = 0, n_tests = 0, f;
  logic [7:0]  ra [7] = '{8'h00, 8'h04, 8'h08, 8'h10, 8'h18, 8'h1C, 8'h20};
  logic [33:0] re [7] = '{34'h0, 34'hFF, 34'h0, 34'h60, 34'h0, 34'h0, 34'h200000000};
  fasp_serial_port dut (.*);
  fasp_line_model m (.aclk(aclk), .txd_out(txd_out), .txd_oe(txd_oe),
    .rxd_in(rxd_in), .sck_in(sck_in));
  // Bus clock
  initial forever #50 aclk = ~aclk;
  task chk(input string nm, input logic [33:0] s, input logic [33:0] e);
    n_tests++;
    if (s !== e) begin
      n_fail++;
      $display("ERROR %s exp %h seen %h", nm, e, s);
    end
  endtask
  task results;
    if (n_fail == 0 && n_tests > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // Handshakes are judged at the falling edge, acted on after the rising one
  task wr(input logic [7:0] a, input logic [31:0] dd);
    logic ta, tw, bv;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= dd;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(negedge aclk);
      ta = s_axi_awvalid & s_axi_awready;
      tw = s_axi_wvalid & s_axi_wready;
      bv = s_axi_bvalid;
      @(posedge aclk);
      if (ta) s_axi_awvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
    end while (!bv);
    s_axi_bready <= 1'b0;
    @(negedge aclk);
  endtask
  task rd(input logic [7:0] a);
    logic ta, rv;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(negedge aclk);
      ta = s_axi_arvalid & s_axi_arready;
      rv = s_axi_rvalid;
      v = {s_axi_rresp, s_axi_rdata};
      @(posedge aclk);
      if (ta) s_axi_arvalid <= 1'b0;
    end while (!rv);
    s_axi_rready <= 1'b0;
    @(negedge aclk);
  endtask
  task wm(input int n);
    for (int i = 0; i < 3000 && m.n_rx < n; i++) @(posedge aclk);
  endtask
  // Watchdog well beyond the expected run
  initial begin
    #3000000;
    n_fail++;
    results;
  end
  // Main sequence
  initial begin
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    for (f = 0; f < 7; f++) begin
      rd(ra[f]);
      chk("reset", v, re[f]);
    end
    for (f = 0; f < 8; f++) begin
      wr(8'h08, 32'h03);
      chk("sck_oe", sck_oe, 1);
      wr(8'h18, 32'h04);
      wr(8'h18, 32'h00);
      wr(8'h00, {25'h0, f[2], f[1], 1'b0, f[0], 3'h0});
      wr(8'h04, 32'h00);
      m.nb = f[2] ? 7 : 8;
      m.par = f[1];
      m.two = f[0];
      mk = f[2] ? 8'h7F : 8'hFF;
      repeat (32) @(posedge aclk);
      wr(8'h08, 32'h33);
      chk("mark", txd_out, 1);
      d = 8'hB4 + f[7:0] * 8'h1D;
      wr(8'h0C, {24'h0, d});
      wm(f + 1);
      chk("tx_data", m.got, d & mk);
      chk("tx_frame", m.n_bad, 0);
      m.send(~d, 1'b0);
      rd(8'h1C);
      chk("rx_count", v, 34'h1);
      rd(8'h14);
      chk("rx_data", v, {26'h0, ~d & mk});
    end
    // Framing fault, flag clearing, directions off
    wr(8'h00, 32'h00);
    m.nb = 8;
    m.par = 1'b0;
    m.two = 1'b0;
    m.send(8'h11, 1'b0);
    m.send(8'h22, 1'b0);
    rd(8'h10);
    m.send(8'h33, 1'b1);
    wr(8'h10, 32'h00);
    wr(8'h08, 32'h03);
    rd(8'h10);
    chk("err_flag", v[3] & v[1], 1);
    rd(8'h1C);
    chk("rx_kept", v, 34'h3);
    wr(8'h10, 32'h77);
    rd(8'h10);
    chk("err_clear", v[3], 0);
    for (f = 0; f < 17; f++) wr(8'h0C, f);
    rd(8'h1C);
    chk("tx_full", v[12:8], 16);
    wr(8'h10, 32'h5F);
    rd(8'h10);
    chk("tx_low", v[5], 0);
    wr(8'h18, 32'h04);
    rd(8'h10);
    chk("tx_low", v[5], 1);
    wr(8'h18, 32'h00);
    // Transmit disabled in mid-frame
    wr(8'h08, 32'h23);
    wr(8'h0C, 32'h81);
    repeat (100) @(posedge aclk);
    wr(8'h08, 32'h03);
    chk("tx_oe", txd_oe, 0);
    // External 16x clock
    wr(8'h18, 32'h04);
    wr(8'h18, 32'h00);
    wr(8'h08, 32'h02);
    chk("sck_oe", sck_oe, 0);
    repeat (500) @(posedge aclk);
    m.bit_cyc = 128;
    f = m.n_rx;
    wr(8'h08, 32'h32);
    wr(8'h0C, 32'h3C);
    wm(f + 1);
    chk("ext_data", m.got, 8'h3C);
    results;
  end
endmodule
